//--- rtl/mlap_fifo.sv
// Synchronous FIFO of packet beats with valid/ready on both sides.
// Assumes one clock; flip-flop storage indexed by pointers.
`timescale 1ns/100ps
module mlap_fifo #(
   parameter int unsigned WIDTH = 9,
   parameter int unsigned DEPTH = 8
) (
   input wire logic ref_clk, // Clock
   input wire logic rst, // Sync reset
   input wire logic [WIDTH-1:0] in_data, // Write word
   input wire logic in_valid, // Write request
   output logic in_ready, // Not full
   output logic [WIDTH-1:0] out_data, // Head word
   output logic out_valid, // Not empty
   input wire logic out_ready // Pop
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;

   assign in_ready = (cnt_q != DEPTH[AW:0]);
   assign out_valid = (cnt_q != '0);
   assign out_data = mem_q[rd_q];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   fifo_bound_a: assert property (@(posedge ref_clk) disable iff (rst)
      cnt_q <= DEPTH[AW:0]) else $error("fifo count past depth");
endmodule

//--- rtl/mlap_pkg.sv
// Package for the multidrop line access port: config carriers, modes, timing.
// Assumes a single 200 MHz clock domain; all users import mlap_pkg::*.
package mlap_pkg;

   // ****************************************
   // Timing
   // ****************************************
   localparam int unsigned CLK_HZ = 200_000_000;
   localparam int unsigned SLICE_UNIT_MS = 10;
   localparam int unsigned SLICE_UNIT_CYC = CLK_HZ / 1000 * SLICE_UNIT_MS;
   localparam logic [7:0] SLICE_MIN = 8'h05;
   localparam logic [7:0] IDLE_GAP_CHARS = 8'h04;

   // ****************************************
   // Frame format
   // ****************************************
   localparam int unsigned DATA_W = 8;
   localparam int unsigned FIFO_DEPTH = 8;
   localparam logic [7:0] ADDR_RST = 8'h00;

   typedef enum logic [1:0] {
      MLAP_DRV_FULL_DUPLEX,
      MLAP_DRV_HALF_DUPLEX,
      MLAP_DRV_TWO_WIRE
   } mlap_drv_t;

   typedef struct packed {
      logic [7:0] node_count;
      logic [7:0] priority_val;
      logic [7:0] time_slice;
      logic [7:0] own_addr;
      mlap_drv_t drv_mode;
   } mlap_cfg_t;

   typedef struct packed {
      logic last;
      logic [DATA_W-1:0] data;
   } mlap_beat_t;

endpackage

//--- rtl/mlap_port.sv
// Multidrop line access port: slotted RTS/CTS access, address filter, driver control.
// Assumes an external UART: tx beats go to it, rx bytes come from it, char_tick per char time.
// Notes on behaviour
// - With a packet pending, raise RTS; send nothing until CTS is active.
// - After CTS, send the packet, then wait for the addressed node's reply.
// - Watch all traffic, accept only own-address packets, pass them on for routing.
// - Line access by time division from node count and own priority.
// - Works whether or not own transmit data echoes back.
// - Full duplex setting: transmitter always enabled, receiver always active.
// - Half duplex setting: transmitter always on, receiver off while transmitting.
// - Two-wire setting: driver follows CTS, receiver off while transmitting.
`timescale 1ns/100ps
module mlap_port
   import mlap_pkg::*;
#(
   parameter int unsigned REPLY_WAIT_CYC = 200_000_000,
   parameter int unsigned SLICE_CYC = SLICE_UNIT_CYC
) (
   input wire logic ref_clk, // 200 MHz clock
   input wire logic rst, // Sync reset, high
   input wire mlap_cfg_t cfg, // Static configuration
   input wire logic cts_pin, // Clear to send pin
   input wire logic rx_line_act, // Line carrier/activity pin
   input wire logic [7:0] rx_byte, // Received byte from UART
   input wire logic rx_byte_valid, // Received byte strobe
   input wire logic rx_byte_last, // Received byte ends packet
   input wire logic char_tick, // One char time elapsed, pulse
   input wire mlap_beat_t tx_beat, // Packet beat to send
   input wire logic tx_beat_valid, // Beat valid
   output logic tx_beat_ready, // Beat accepted into FIFO
   input wire logic uart_tx_ready, // UART may take a byte
   input wire logic uart_tx_idle, // UART shifter empty
   output logic [7:0] uart_tx_data, // Byte to UART
   output logic uart_tx_load, // Load pulse to UART
   output logic rts_pin, // Request to send
   output logic drv_oe_n, // Transmit driver enable, low = drive
   output logic rcv_en, // Receiver enable
   output mlap_beat_t rx_out, // Accepted packet beat
   output logic rx_out_valid, // Accepted beat strobe
   output logic reply_timeout // Reply wait expired, pulse
);

   // ****************************************
   // Input synchronisers
   // ****************************************
   logic cts_m_q, cts_q, act_m_q, act_q;
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cts_m_q <= 1'b0;
         cts_q <= 1'b0;
         act_m_q <= 1'b0;
         act_q <= 1'b0;
      end else begin
         cts_m_q <= cts_pin;
         cts_q <= cts_m_q;
         act_m_q <= rx_line_act;
         act_q <= act_m_q;
      end
   end

   // ****************************************
   // Transmit FIFO
   // ****************************************
   mlap_beat_t fifo_head;
   logic fifo_valid, fifo_pop;
   mlap_fifo #(.WIDTH($bits(mlap_beat_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
      .ref_clk(ref_clk),
      .rst(rst),
      .in_data(tx_beat),
      .in_valid(tx_beat_valid),
      .in_ready(tx_beat_ready),
      .out_data(fifo_head),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop)
   );

   // ****************************************
   // Slice timer
   // ****************************************
   typedef enum logic [2:0] {
      ST_IDLE, ST_WAIT_SLOT, ST_REQ, ST_SEND, ST_DRAIN, ST_REPLY
   } mlap_state_t;
   mlap_state_t st_q;

   logic [31:0] unit_q;
   logic [7:0] hund_q, slot_q;
   logic slice_tick;
   logic [7:0] slice_eff;
   logic line_busy;
   logic own_tx;

   // Short slices starve the RTS-CTS window, so clamp up
   assign slice_eff = (cfg.time_slice < SLICE_MIN) ? SLICE_MIN : cfg.time_slice;
   assign own_tx = (st_q == ST_SEND) || (st_q == ST_DRAIN);
   // Own echo is ignored as traffic while we hold the line
   assign line_busy = (act_q || rx_byte_valid) && !own_tx;
   assign slice_tick = (hund_q == slice_eff - 8'h01) && (unit_q == SLICE_CYC - 1);

   always_ff @(posedge ref_clk) begin
      if (rst || line_busy) begin
         unit_q <= '0;
         hund_q <= '0;
      end else if (unit_q == SLICE_CYC - 1) begin
         unit_q <= '0;
         hund_q <= slice_tick ? 8'h00 : hund_q + 8'h01;
      end else begin
         unit_q <= unit_q + 32'd1;
      end
   end

   // Slots counted since the line went idle; wraps after node_count
   always_ff @(posedge ref_clk) begin
      if (rst || line_busy) begin
         slot_q <= '0;
      end else if (slice_tick) begin
         slot_q <= (slot_q + 8'h01 >= cfg.node_count) ? 8'h00 : slot_q + 8'h01;
      end
   end

   // ****************************************
   // Access state machine
   // ****************************************
   logic my_slot;
   logic [31:0] wait_q;
   assign my_slot = slice_tick && (slot_q + 8'h01 == cfg.priority_val);
   assign fifo_pop = (st_q == ST_SEND) && cts_q && uart_tx_ready && !uart_tx_load;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st_q <= ST_IDLE;
      end else begin
         case (st_q)
            ST_IDLE: begin
               if (fifo_valid) begin
                  st_q <= ST_WAIT_SLOT;
               end
            end
            ST_WAIT_SLOT: begin
               if (my_slot) begin
                  st_q <= ST_REQ;
               end
            end
            ST_REQ: begin
               if (cts_q) begin
                  st_q <= ST_SEND;
               end
            end
            ST_SEND: begin
               if (fifo_pop && fifo_head.last) begin
                  st_q <= ST_DRAIN;
               end
            end
            ST_DRAIN: begin
               if (uart_tx_idle && uart_tx_ready && !uart_tx_load) begin
                  st_q <= ST_REPLY;
               end
            end
            ST_REPLY: begin
               if ((rx_out_valid && rx_out.last) || wait_q == REPLY_WAIT_CYC - 1) begin
                  st_q <= ST_IDLE;
               end
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst || st_q != ST_REPLY) begin
         wait_q <= '0;
      end else begin
         wait_q <= wait_q + 32'd1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         reply_timeout <= 1'b0;
      end else begin
         reply_timeout <= (st_q == ST_REPLY) && (wait_q == REPLY_WAIT_CYC - 1);
      end
   end

   // ****************************************
   // Transmit path and pins
   // ****************************************
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         uart_tx_data <= '0;
         uart_tx_load <= 1'b0;
      end else begin
         uart_tx_load <= fifo_pop;
         if (fifo_pop) begin
            uart_tx_data <= fifo_head.data;
         end
      end
   end

   logic rts_d;
   assign rts_d = (st_q == ST_REQ) || (st_q == ST_SEND) || (st_q == ST_DRAIN);
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rts_pin <= 1'b0;
      end else begin
         rts_pin <= rts_d;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         drv_oe_n <= 1'b1;
         rcv_en <= 1'b0;
      end else begin
         case (cfg.drv_mode)
            MLAP_DRV_HALF_DUPLEX: begin
               drv_oe_n <= 1'b0;
               rcv_en <= !rts_d;
            end
            MLAP_DRV_TWO_WIRE: begin
               drv_oe_n <= !cts_q;
               rcv_en <= !rts_d;
            end
            default: begin
               drv_oe_n <= 1'b0;
               rcv_en <= 1'b1;
            end
         endcase
      end
   end

   // ****************************************
   // Receive address filter
   // ****************************************
   logic first_q, match_q;
   logic addr_hit;
   assign addr_hit = (rx_byte == cfg.own_addr);

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         first_q <= 1'b1;
         match_q <= 1'b0;
      end else if (rx_byte_valid && !own_tx) begin
         first_q <= rx_byte_last;
         if (first_q) begin
            match_q <= addr_hit && !rx_byte_last;
         end else if (rx_byte_last) begin
            match_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rx_out <= '0;
         rx_out_valid <= 1'b0;
      end else begin
         rx_out_valid <= rx_byte_valid && !own_tx && (first_q ? addr_hit : match_q);
         rx_out.data <= rx_byte;
         rx_out.last <= rx_byte_last;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   sequence grant_s;
      rts_pin && cts_q;
   endsequence

   no_tx_cts_a: assert property (@(posedge ref_clk) disable iff (rst)
      fifo_pop |-> cts_q && rts_pin) else $error("byte sent without CTS");
   rts_slot_a: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(rts_pin) |-> $past(my_slot, 2)) else $error("RTS outside own slot");
   load_follow_a: assert property (@(posedge ref_clk) disable iff (rst)
      grant_s ##0 fifo_pop |=> uart_tx_load) else $error("popped byte not loaded");
   rts_drop_a: assert property (@(posedge ref_clk) disable iff (rst)
      $fell(rts_pin) |-> $past(uart_tx_idle, 2)) else $error("RTS dropped while busy");
   full_dup_a: assert property (@(posedge ref_clk) disable iff (rst)
      cfg.drv_mode == MLAP_DRV_FULL_DUPLEX ##1 cfg.drv_mode == MLAP_DRV_FULL_DUPLEX
      |-> !drv_oe_n && rcv_en) else $error("full duplex pins wrong");
   half_dup_a: assert property (@(posedge ref_clk) disable iff (rst)
      cfg.drv_mode == MLAP_DRV_HALF_DUPLEX ##1 cfg.drv_mode == MLAP_DRV_HALF_DUPLEX
      |-> !drv_oe_n && (rcv_en == !rts_pin)) else $error("half duplex pins wrong");
   two_wire_a: assert property (@(posedge ref_clk) disable iff (rst)
      cfg.drv_mode == MLAP_DRV_TWO_WIRE ##1 cfg.drv_mode == MLAP_DRV_TWO_WIRE
      |-> (drv_oe_n == !$past(cts_q)) && (rcv_en == !rts_pin)) else $error("two wire pins wrong");
   addr_filter_a: assert property (@(posedge ref_clk) disable iff (rst)
      rx_byte_valid && first_q && !own_tx && !addr_hit |=> !rx_out_valid)
      else $error("foreign packet accepted");
   echo_ignore_a: assert property (@(posedge ref_clk) disable iff (rst)
      own_tx |=> !rx_out_valid) else $error("own echo accepted");
   slot_range_a: assert property (@(posedge ref_clk) disable iff (rst)
      cfg.node_count != 8'h00 |-> slot_q < cfg.node_count) else $error("slot past node count");
endmodule

//--- testbench/mlap_line_model.sv
// Behavioural line interface: shared pair plus transceiver, seen from one node.
// Assumes the node clock; peers' packets are queued by the bench through send_pkt.
`timescale 1ns/100ps
module mlap_line_model #(
   parameter int unsigned CTS_DELAY = 3
) (
   ref_clk, // Clock
   rts_pin, // Request from node
   cts_spur, // Commanded stray CTS
   echo_en, // Return own data
   uart_tx_data, // Byte leaving node
   uart_tx_load, // Byte strobe
   cts_pin, // Clear to send
   rx_line_act, // Line activity
   rx_byte, // Byte heard on line
   rx_byte_valid, // Byte strobe
   rx_byte_last // End of packet
);
   input wire logic ref_clk;
   input wire logic rts_pin;
   input wire logic cts_spur;
   input wire logic echo_en;
   input wire logic [7:0] uart_tx_data;
   input wire logic uart_tx_load;
   output logic cts_pin;
   output logic rx_line_act;
   output logic [7:0] rx_byte;
   output logic rx_byte_valid;
   output logic rx_byte_last;

   logic [8:0] pend[$];
   logic [8:0] b;
   int unsigned wait_q;

   initial begin
      cts_pin = 1'b0;
      rx_line_act = 1'b0;
      rx_byte = 8'h00;
      rx_byte_valid = 1'b0;
      rx_byte_last = 1'b0;
      wait_q = 0;
   end

   // ****************************************
   // Peer traffic, heard by every node
   // ****************************************
   task automatic send_pkt(input logic [7:0] a, input logic [7:0] d0, input logic [7:0] d1);
      pend.push_back({1'b0, a});
      pend.push_back({1'b0, d0});
      pend.push_back({1'b1, d1});
   endtask

   always @(posedge ref_clk) begin
      // Turnaround delay before CTS, held while RTS holds
      if (!rts_pin) wait_q <= 0;
      else if (wait_q < CTS_DELAY) wait_q <= wait_q + 1;
      cts_pin <= #1 cts_spur || (rts_pin && wait_q >= CTS_DELAY);
      if (uart_tx_load && echo_en) pend.push_back({1'b0, uart_tx_data});
      if (pend.size() > 0) begin
         b = pend.pop_front();
         rx_byte <= #1 b[7:0];
         rx_byte_valid <= #1 1'b1;
         rx_byte_last <= #1 b[8];
         rx_line_act <= #1 1'b1;
      end else begin
         // Released line: data keeps moving so no stale byte looks valid
         rx_byte <= #1 ~rx_byte;
         rx_byte_valid <= #1 1'b0;
         rx_byte_last <= #1 1'b0;
         rx_line_act <= #1 1'b0;
      end
   end
endmodule

//--- testbench/tb_multidrop_line_access_port.sv
// Bench for the line access port: driver modes, address filter, transmit FIFO.
// Assumes a shortened slice unit of 10 cycles, so own slots arrive within the run.
`timescale 1ns/100ps
module tb_multidrop_line_access_port;
   import mlap_pkg::*;

   logic ref_clk, rst, cts_pin, rx_line_act, rx_byte_valid, rx_byte_last, char_tick;
   logic tx_beat_valid, tx_beat_ready, uart_tx_ready, uart_tx_idle, uart_tx_load;
   logic rts_pin, drv_oe_n, rcv_en, rx_out_valid, reply_timeout, cts_spur, echo_en;
   logic [7:0] rx_byte, uart_tx_data;
   mlap_cfg_t cfg;
   mlap_beat_t tx_beat, rx_out;
   logic [8:0] got_q[$];
   int err_count, total_checks, stray, n;
   logic [7:0] tx_q[$];
   int tmo_n, k;
   logic mon_en;

   mlap_port #(.REPLY_WAIT_CYC(200), .SLICE_CYC(10)) i_mlap_port (.ref_clk(ref_clk), .rst(rst), .cfg(cfg),
      .cts_pin(cts_pin), .rx_line_act(rx_line_act), .rx_byte(rx_byte), .rx_byte_valid(rx_byte_valid),
      .rx_byte_last(rx_byte_last), .char_tick(char_tick), .tx_beat(tx_beat), .tx_beat_valid(tx_beat_valid),
      .tx_beat_ready(tx_beat_ready), .uart_tx_ready(uart_tx_ready), .uart_tx_idle(uart_tx_idle),
      .uart_tx_data(uart_tx_data), .uart_tx_load(uart_tx_load), .rts_pin(rts_pin), .drv_oe_n(drv_oe_n),
      .rcv_en(rcv_en), .rx_out(rx_out), .rx_out_valid(rx_out_valid), .reply_timeout(reply_timeout));

   mlap_line_model i_mlap_line_model (.ref_clk(ref_clk), .rts_pin(rts_pin), .cts_spur(cts_spur),
      .echo_en(echo_en), .uart_tx_data(uart_tx_data), .uart_tx_load(uart_tx_load), .cts_pin(cts_pin),
      .rx_line_act(rx_line_act), .rx_byte(rx_byte), .rx_byte_valid(rx_byte_valid),
      .rx_byte_last(rx_byte_last));

   always #2.5 ref_clk = ~ref_clk;

   // ****************************************
   // Monitors
   // ****************************************
   always @(posedge ref_clk) begin
      if (rx_out_valid === 1'b1) got_q.push_back({rx_out.last, rx_out.data});
      if (mon_en && !rst && (rts_pin !== 1'b0 || uart_tx_load !== 1'b0 || reply_timeout !== 1'b0)) stray++;
      if (uart_tx_load === 1'b1) tx_q.push_back(uart_tx_data);
      if (reply_timeout === 1'b1) tmo_n++;
   end

   // ****************************************
   // Tasks
   // ****************************************
   task automatic end_sim();
      $display("Checks %0d, mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
      total_checks++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", name, exp, got);
         err_count++;
      end
   endtask

   task automatic do_reset(input int m);
      rst = 1'b1;
      cfg.drv_mode = mlap_drv_t'(m[1:0]);
      repeat (2) @(posedge ref_clk);
      #1 rst = 1'b0;
      repeat (4) @(posedge ref_clk);
      #1;
   endtask

   // Driver enable reaches its level within a bounded sync delay
   task automatic wait_oe(input logic v);
      int k;
      k = 0;
      while (drv_oe_n !== v && k < 10) begin
         @(posedge ref_clk);
         #1 k++;
      end
      chk("drv_oe_n", {8'h00, v}, {8'h00, drv_oe_n});
      if (drv_oe_n !== v) end_sim();
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      ref_clk = 1'b0;
      rst = 1'b1;
      char_tick = 1'b0;
      cts_spur = 1'b0;
      echo_en = 1'b1;
      uart_tx_ready = 1'b1;
      uart_tx_idle = 1'b1;
      tx_beat = '0;
      tx_beat_valid = 1'b0;
      err_count = 0;
      total_checks = 0;
      stray = 0;
      n = 0;
      tmo_n = 0;
      k = 0;
      mon_en = 1'b1;
      // Same count and slice on all nodes, unique priority, slice at its floor
      cfg = '{node_count: 8'h03, priority_val: 8'h02, time_slice: 8'h05, own_addr: 8'h11,
              drv_mode: MLAP_DRV_FULL_DUPLEX};
      for (int m = 0; m < 3; m++) begin
         do_reset(m);
         chk("rcv_en", 9'h001, {8'h00, rcv_en});
         wait_oe(m == 2);
      end
      // Two-wire: driver follows CTS even with no request pending
      cts_spur = 1'b1;
      wait_oe(1'b0);
      chk("rcv_en", 9'h001, {8'h00, rcv_en});
      cts_spur = 1'b0;
      wait_oe(1'b1);
      // Own, foreign, then two own packets back to back
      i_mlap_line_model.send_pkt(8'h11, 8'h5A, 8'hC3);
      i_mlap_line_model.send_pkt(8'h12, 8'hA5, 8'h3C);
      i_mlap_line_model.send_pkt(8'h11, 8'h00, 8'hFF);
      i_mlap_line_model.send_pkt(8'h11, 8'h7E, 8'h81);
      repeat (20) @(posedge ref_clk);
      #1 chk("rx count", 9'h009, 9'(got_q.size()));
      chk("rx b0", 9'h011, got_q[0]);
      chk("rx b2", 9'h1C3, got_q[2]);
      chk("rx b3", 9'h011, got_q[3]);
      chk("rx b5", 9'h1FF, got_q[5]);
      chk("rx b7", 9'h07E, got_q[7]);
      chk("rx b8", 9'h181, got_q[8]);
      // Fill the transmit FIFO until it refuses
      tx_beat_valid = 1'b1;
      for (int i = 0; i < 16 && tx_beat_ready === 1'b1; i++) begin
         tx_beat.data = i[7:0];
         tx_beat.last = (i == FIFO_DEPTH - 1);
         @(posedge ref_clk);
         #1 n++;
      end
      tx_beat_valid = 1'b0;
      chk("fifo depth", 9'(FIFO_DEPTH), 9'(n));
      // Stray CTS with a full FIFO: no request and no byte before the slot
      cts_spur = 1'b1;
      repeat (30) @(posedge ref_clk);
      #1 cts_spur = 1'b0;
      repeat (5) @(posedge ref_clk);
      #1 chk("stray tx", 9'h000, 9'(stray));
      mon_en = 1'b0;
      // Own slot: RTS, CTS, eight bytes, RTS released after the last
      while (rts_pin !== 1'b1 && k < 400) begin
         @(posedge ref_clk);
         #1 k++;
      end
      chk("rts rise", 9'h001, {8'h00, rts_pin});
      k = 0;
      while (rts_pin !== 1'b0 && k < 400) begin
         @(posedge ref_clk);
         #1 k++;
      end
      chk("rts fall", 9'h000, {8'h00, rts_pin});
      chk("tx count", 9'(FIFO_DEPTH), 9'(tx_q.size()));
      chk("tx b0", 9'h000, {1'b0, tx_q[0]});
      chk("tx b7", 9'h007, {1'b0, tx_q[7]});
      chk("echo kept out", 9'h009, 9'(got_q.size()));
      // Addressed reply ends the wait before the timeout
      i_mlap_line_model.send_pkt(8'h11, 8'h42, 8'h24);
      repeat (250) @(posedge ref_clk);
      #1 chk("reply b2", 9'h124, got_q[11]);
      chk("no timeout", 9'h000, 9'(tmo_n));
      // No reply: wait expires once
      tx_beat = '{last: 1'b1, data: 8'hA5};
      tx_beat_valid = 1'b1;
      @(posedge ref_clk);
      #1 tx_beat_valid = 1'b0;
      repeat (450) @(posedge ref_clk);
      #1 chk("reply timeout", 9'h001, 9'(tmo_n));
      chk("tx last", 9'h0A5, {1'b0, tx_q[8]});
      end_sim();
   end
endmodule
